/* File: scr_core_regs.v */
// Serial-port register bank for synthesizer core control and status
`timescale 1ns/100ps
`include "scr_defines.vh"
module scr_core_regs #(
  // Arbitrary neutral identity value
  parameter [23:0] ID_WORD = 24'h5a0c3e
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Serial control port pins
  input wire spi_sck,
  input wire spi_sen,
  input wire spi_sdi,
  output reg lock_or_serial_out_pin,
  output wire lock_or_serial_out_pin_oe,
  // Lock status from the detector
  input wire lock_detect,
  // Phase detector pulses and gated pump commands
  input wire pfd_up_raw,
  input wire pfd_dn_raw,
  output wire pump_up_cmd,
  output wire pump_dn_cmd,
  output wire pump_output_oe,
  // Strobes
  output reg digital_soft_reset,
  output reg temp_sample_strobe,
  // Enables and resets
  output reg vco_buffer_on,
  output reg bias_on,
  output reg ref_divider_run,
  output reg xmux_clk_to_dig_on,
  output reg rdiv_clk_to_dig_on,
  output reg sqr_clk_to_dig_on,
  output reg sin_clk_to_dig_on,
  output reg square_ref_buffer_on,
  output reg sine_ref_buffer_on,
  output reg mod_clk_from_vco,
  output reg prescaler_bias_on,
  output reg pfd_lock_gate_run,
  output reg pump_output_on,
  output reg modulator_run,
  output reg lock_detect_run,
  output reg slip_prevention_run,
  // Reference path
  output reg [13:0] ref_div_ratio,
  output reg ref_divider_in_use,
  output reg sine_ref_select,
  // Prescaler, phase detector and pump
  output reg prescaler_long_low,
  output reg [2:0] pfd_delay_setpoint,
  output reg [4:0] pump_up_current_code,
  output reg [4:0] pump_down_current_code
);

  // Filtered copies of the asynchronous inputs
  wire sck_q;
  wire sen_q;
  wire sdi_q;
  wire lock_q;
  reg sck_prev_q;

  // Frame state
  reg [5:0] bit_cnt_q;
  reg [31:0] shift_in_q;
  reg [23:0] shift_out_q;
  reg read_mode_q;
  reg [5:0] addr_q;

  // Register storage
  reg [15:0] enable_q;
  reg [1:0] sdo_force_q;
  reg [16:0] refpath_q;
  reg presc_q;
  reg [2:0] pfd_q;
  reg [2:0] pfd_delay_q;
  reg [9:0] pump_q;

  wire sck_rise;
  wire [31:0] shift_next;
  wire addr_done;
  wire write_commit;
  wire strobe_write;
  wire [15:0] enable_reset_val;
  wire [23:0] wdata;
  wire regs_reset;
  reg [23:0] rdata;
  reg pfd_up_sel;
  reg pfd_dn_sel;

  // Serial clock, enable and data from the pins
  scr_pin_sync #(
    .RESET_LEVEL(1'b0)
  ) scr_pin_sync_sck_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(spi_sck),
    .level_q(sck_q)
  );

  scr_pin_sync #(
    .RESET_LEVEL(1'b0)
  ) scr_pin_sync_sen_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(spi_sen),
    .level_q(sen_q)
  );

  scr_pin_sync #(
    .RESET_LEVEL(1'b0)
  ) scr_pin_sync_sdi_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(spi_sdi),
    .level_q(sdi_q)
  );

  // Lock status comes from the reference clock domain
  scr_pin_sync #(
    .RESET_LEVEL(1'b0)
  ) scr_pin_sync_lock_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(lock_detect),
    .level_q(lock_q)
  );

  // Edge history of the filtered serial clock
  always @(posedge clk_sys) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_q;
    end
  end

  assign sck_rise = sck_q & ~sck_prev_q & sen_q;
  assign shift_next = {shift_in_q[30:0], sdi_q};
  assign addr_done = sck_rise && (bit_cnt_q == `SCR_CNT_ADDR_DONE);
  assign write_commit = sck_rise && (bit_cnt_q == `SCR_CNT_LAST) && !read_mode_q;
  assign wdata = shift_next[23:0];
  // Address zero stores no data; its written bits are strobes
  assign strobe_write = write_commit && (addr_q == `SCR_ADDR_ID_STROBE);
  assign enable_reset_val = `SCR_RST_ENABLE;
  // Serial register soft reset acts on the commit cycle itself
  assign regs_reset = strobe_write && wdata[`SCR_STB_REGS];

  // Readback mux
  // Unmapped addresses read as zero
  always @* begin
    rdata = 24'h000000;
    case (shift_next[5:0])
      `SCR_ADDR_ID_STROBE: rdata = ID_WORD;
      `SCR_ADDR_ENABLE: rdata = {8'h00, enable_q};
      `SCR_ADDR_SDO_FORCE: rdata = {22'h000000, sdo_force_q};
      `SCR_ADDR_REFPATH: rdata = {7'h00, refpath_q};
      `SCR_ADDR_PRESC: rdata = {23'h000000, presc_q};
      `SCR_ADDR_PFD: rdata = {21'h000000, pfd_q};
      `SCR_ADDR_PFD_DELAY: rdata = {21'h000000, pfd_delay_q};
      `SCR_ADDR_PUMP: rdata = {14'h0000, pump_q};
      default: rdata = 24'h000000;
    endcase
  end

  // Frame sequencing
  // Read flag, spare bit, six address bits, then 24 data bits
  // Dropping the enable aborts a frame at any bit
  always @(posedge clk_sys) begin
    if (rst) begin
      bit_cnt_q <= 6'h00;
      shift_in_q <= 32'h00000000;
      shift_out_q <= 24'h000000;
      read_mode_q <= 1'b0;
      addr_q <= 6'h00;
    end else if (!sen_q) begin
      bit_cnt_q <= 6'h00;
      read_mode_q <= 1'b0;
    end else if (sck_rise) begin
      shift_in_q <= shift_next;
      bit_cnt_q <= bit_cnt_q + 6'h01;
      if (addr_done) begin
        addr_q <= shift_next[5:0];
        read_mode_q <= shift_next[`SCR_READ_FLAG_BIT];
        shift_out_q <= rdata;
      end else if (bit_cnt_q > `SCR_CNT_ADDR_DONE) begin
        shift_out_q <= {shift_out_q[22:0], 1'b0};
      end
    end
  end

  // Serial out pin: force, then read data, then lock status
  always @(posedge clk_sys) begin
    if (rst) begin
      lock_or_serial_out_pin <= 1'b1;
    end else if (sdo_force_q[`SCR_FRC_EN]) begin
      lock_or_serial_out_pin <= sdo_force_q[`SCR_FRC_VAL];
    end else if (read_mode_q && sen_q) begin
      // Read data leaves on each rise after the address
      if (sck_rise) begin
        lock_or_serial_out_pin <= shift_out_q[23];
      end
    end else begin
      lock_or_serial_out_pin <= lock_q;
    end
  end
  assign lock_or_serial_out_pin_oe = 1'b1;

  // Write-only strobes, single pulses
  always @(posedge clk_sys) begin
    if (rst) begin
      digital_soft_reset <= 1'b0;
      temp_sample_strobe <= 1'b0;
    end else begin
      // Zero bits and the reserved bit raise nothing
      digital_soft_reset <= strobe_write && wdata[`SCR_STB_DIG];
      temp_sample_strobe <= strobe_write && wdata[`SCR_STB_TEMP];
    end
  end

  // Register storage
  always @(posedge clk_sys) begin
    // Soft register reset wins over the write it comes with
    if (rst || regs_reset) begin
      enable_q <= `SCR_RST_ENABLE;
      sdo_force_q <= `SCR_RST_SDO_FORCE;
      refpath_q <= `SCR_RST_REFPATH;
      presc_q <= `SCR_RST_PRESC;
      pfd_q <= `SCR_RST_PFD;
      pfd_delay_q <= `SCR_RST_PFD_DELAY;
      pump_q <= `SCR_RST_PUMP;
    end else if (write_commit) begin
      case (addr_q)
        `SCR_ADDR_ENABLE: enable_q <= wdata[15:0];
        `SCR_ADDR_SDO_FORCE: sdo_force_q <= wdata[1:0];
        `SCR_ADDR_REFPATH: refpath_q <= wdata[16:0];
        `SCR_ADDR_PRESC: presc_q <= wdata[0];
        `SCR_ADDR_PFD: pfd_q <= wdata[2:0];
        `SCR_ADDR_PFD_DELAY: pfd_delay_q <= wdata[2:0];
        `SCR_ADDR_PUMP: pump_q <= wdata[9:0];
        default: ;
      endcase
    end
  end

  // Control outputs from flops, one clock behind the registers
  always @(posedge clk_sys) begin
    if (rst) begin
      // Reset pattern of the enable register, bit by bit
      vco_buffer_on <= enable_reset_val[`SCR_EN_VCOBUF];
      bias_on <= enable_reset_val[`SCR_EN_BIAS];
      ref_divider_run <= enable_reset_val[`SCR_EN_REFDIV];
      xmux_clk_to_dig_on <= enable_reset_val[`SCR_EN_XMUX_DIG];
      rdiv_clk_to_dig_on <= enable_reset_val[`SCR_EN_RDIV_DIG];
      sqr_clk_to_dig_on <= enable_reset_val[`SCR_EN_SQR_DIG];
      sin_clk_to_dig_on <= enable_reset_val[`SCR_EN_SIN_DIG];
      square_ref_buffer_on <= enable_reset_val[`SCR_EN_SQ_BUF];
      sine_ref_buffer_on <= enable_reset_val[`SCR_EN_SIN_BUF];
      mod_clk_from_vco <= enable_reset_val[`SCR_EN_MODCLK_VCO];
      prescaler_bias_on <= enable_reset_val[`SCR_EN_PRESC];
      pfd_lock_gate_run <= enable_reset_val[`SCR_EN_PFD_LKD];
      pump_output_on <= enable_reset_val[`SCR_EN_PUMP];
      modulator_run <= enable_reset_val[`SCR_EN_DSM_RSTB];
      lock_detect_run <= enable_reset_val[`SCR_EN_LKD_RSTB];
      slip_prevention_run <= enable_reset_val[`SCR_EN_SLIP_RSTB];
      ref_div_ratio <= `SCR_RST_RATIO;
      ref_divider_in_use <= 1'b0;
      sine_ref_select <= 1'b0;
      prescaler_long_low <= `SCR_RST_PRESC;
      pfd_delay_setpoint <= `SCR_RST_PFD_DELAY;
      pump_up_current_code <= `SCR_RST_PUMP_UP;
      pump_down_current_code <= `SCR_RST_PUMP_DN;
    end else begin
      vco_buffer_on <= enable_q[`SCR_EN_VCOBUF];
      bias_on <= enable_q[`SCR_EN_BIAS];
      ref_divider_run <= enable_q[`SCR_EN_REFDIV];
      xmux_clk_to_dig_on <= enable_q[`SCR_EN_XMUX_DIG];
      rdiv_clk_to_dig_on <= enable_q[`SCR_EN_RDIV_DIG];
      sqr_clk_to_dig_on <= enable_q[`SCR_EN_SQR_DIG];
      sin_clk_to_dig_on <= enable_q[`SCR_EN_SIN_DIG];
      square_ref_buffer_on <= enable_q[`SCR_EN_SQ_BUF];
      sine_ref_buffer_on <= enable_q[`SCR_EN_SIN_BUF];
      mod_clk_from_vco <= enable_q[`SCR_EN_MODCLK_VCO];
      prescaler_bias_on <= enable_q[`SCR_EN_PRESC];
      pfd_lock_gate_run <= enable_q[`SCR_EN_PFD_LKD];
      pump_output_on <= enable_q[`SCR_EN_PUMP];
      modulator_run <= enable_q[`SCR_EN_DSM_RSTB];
      lock_detect_run <= enable_q[`SCR_EN_LKD_RSTB];
      slip_prevention_run <= enable_q[`SCR_EN_SLIP_RSTB];
      ref_div_ratio <= refpath_q[`SCR_RP_RATIO_MSB:0];
      // Divider held in reset acts as bypass
      if (!enable_q[`SCR_EN_REFDIV]) begin
        ref_divider_in_use <= 1'b0;
      end else if (refpath_q[`SCR_RP_AUTO]) begin
        ref_divider_in_use <= (refpath_q[`SCR_RP_RATIO_MSB:0] != `SCR_RP_RATIO_ONE);
      end else begin
        ref_divider_in_use <= refpath_q[`SCR_RP_SELECT];
      end
      sine_ref_select <= refpath_q[`SCR_RP_SIN_SEL];
      prescaler_long_low <= presc_q;
      pfd_delay_setpoint <= pfd_delay_q;
      pump_up_current_code <= pump_q[`SCR_PUMP_UP_MSB:0];
      pump_down_current_code <= pump_q[`SCR_PUMP_DN_MSB:`SCR_PUMP_DN_LSB];
    end
  end

  // Phase detector polarity and masking toward the pump
  // Pulses stay combinational so the loop sees no added delay
  always @* begin
    if (pfd_q[`SCR_PFD_INVERT]) begin
      pfd_up_sel = pfd_dn_raw;
      pfd_dn_sel = pfd_up_raw;
    end else begin
      pfd_up_sel = pfd_up_raw;
      pfd_dn_sel = pfd_dn_raw;
    end
  end
  assign pump_up_cmd = pfd_up_sel & pfd_q[`SCR_PFD_UP_EN] & pump_output_on;
  assign pump_dn_cmd = pfd_dn_sel & pfd_q[`SCR_PFD_DN_EN] & pump_output_on;
  assign pump_output_oe = pump_output_on;

endmodule // scr_core_regs

// Three-stage synchroniser; a level counts once the last two stages agree
module scr_pin_sync #(
  parameter [0:0] RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Asynchronous input and its filtered level
  input wire pin_in,
  output reg level_q
);

  reg [2:0] stage_q;

  always @(posedge clk_sys) begin
    if (rst) begin
      stage_q <= {3{RESET_LEVEL}};
      level_q <= RESET_LEVEL;
    end else begin
      stage_q <= {stage_q[1:0], pin_in};
      // A level that is still settling is not passed on
      if (stage_q[1] == stage_q[2]) begin
        level_q <= stage_q[2];
      end
    end
  end

endmodule // scr_pin_sync

/* File: scr_core_regs_assertions.sv */
// Concurrent checks on the ports of the synthesizer control bank
`timescale 1ns/100ps
module scr_core_regs_chk (
  // Clock, reset and serial enable
  input wire clk_sys, input wire rst, input wire spi_sen,
  // Pump path
  input wire pfd_up_raw, input wire pfd_dn_raw, input wire pump_up_cmd, input wire pump_dn_cmd,
  input wire pump_output_oe, input wire pump_output_on,
  // Strobes and controls
  input wire digital_soft_reset, input wire temp_sample_strobe, input wire ref_divider_run,
  input wire ref_divider_in_use, input wire modulator_run, input wire slip_prevention_run,
  input wire lock_or_serial_out_pin_oe, input wire [2:0] pfd_delay_setpoint,
  input wire [4:0] pump_up_current_code, input wire [4:0] pump_down_current_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_PUMP_OE: assert property (pump_output_oe == pump_output_on)
    else $error("pump tristate does not follow pump enable");
  AST_PUMP_OFF: assert property (!pump_output_on |-> !pump_up_cmd && !pump_dn_cmd)
    else $error("pump command while pump disabled");
  AST_PUMP_SRC: assert property (pump_up_cmd || pump_dn_cmd |-> pfd_up_raw || pfd_dn_raw)
    else $error("pump command without detector pulse");
  AST_DIG_PULSE: assert property (digital_soft_reset |=> !digital_soft_reset)
    else $error("digital reset strobe longer than one cycle");
  AST_TEMP_PULSE: assert property (temp_sample_strobe |=> !temp_sample_strobe)
    else $error("temperature strobe longer than one cycle");
  AST_REFDIV_OFF: assert property (!ref_divider_run |-> !ref_divider_in_use)
    else $error("divider in use while held in reset");
  AST_RESET_VALS: assert property ($fell(rst) |-> pfd_delay_setpoint == 3'h2 && pump_up_current_code == 5'h10
    && pump_down_current_code == 5'h10 && slip_prevention_run && !modulator_run)
    else $error("wrong control values after reset");
  AST_IDLE_STABLE: assert property ((!spi_sen) [*8] |-> $stable(pump_up_current_code)
    && $stable(pfd_delay_setpoint) && $stable(modulator_run) && !digital_soft_reset)
    else $error("control changed outside a frame");
  AST_PIN_OE: assert property (lock_or_serial_out_pin_oe)
    else $error("serial out pin not driven");
endmodule // scr_core_regs_chk
bind scr_core_regs scr_core_regs_chk scr_core_regs_chk_inst (.clk_sys(clk_sys), .rst(rst), .spi_sen(spi_sen),
  .pfd_up_raw(pfd_up_raw), .pfd_dn_raw(pfd_dn_raw), .pump_up_cmd(pump_up_cmd), .pump_dn_cmd(pump_dn_cmd),
  .pump_output_oe(pump_output_oe), .pump_output_on(pump_output_on), .digital_soft_reset(digital_soft_reset),
  .temp_sample_strobe(temp_sample_strobe), .ref_divider_run(ref_divider_run),
  .ref_divider_in_use(ref_divider_in_use), .modulator_run(modulator_run),
  .slip_prevention_run(slip_prevention_run), .lock_or_serial_out_pin_oe(lock_or_serial_out_pin_oe),
  .pfd_delay_setpoint(pfd_delay_setpoint), .pump_up_current_code(pump_up_current_code),
  .pump_down_current_code(pump_down_current_code));

/* File: scr_core_regs_test.sv */
// Self-checking testbench for the synthesizer control bank
`timescale 1ns/100ps
`include "scr_defines.vh"
module scr_core_regs_test;
  localparam [23:0] ID = 24'h3c5a96; // Arbitrary identity value
  localparam [84:0] RP_TBL = {17'h08001, 17'h08002, 17'h04005, 17'h00005, 17'h1bfff};
  localparam [15:0] STB_TBL = {4'h8, 4'h2, 4'h4, 4'h0};
  reg clk_sys = 1'b0, rst = 1'b1, spi_sck = 1'b0, spi_sen = 1'b0, spi_sdi = 1'b0;
  reg lock_detect = 1'b0, pfd_up_raw = 1'b0, pfd_dn_raw = 1'b0;
  wire lock_or_serial_out_pin, lock_or_serial_out_pin_oe, pump_up_cmd, pump_dn_cmd, pump_output_oe;
  wire digital_soft_reset, temp_sample_strobe, vco_buffer_on, bias_on, ref_divider_run, xmux_clk_to_dig_on;
  wire rdiv_clk_to_dig_on, sqr_clk_to_dig_on, sin_clk_to_dig_on, square_ref_buffer_on, sine_ref_buffer_on;
  wire mod_clk_from_vco, prescaler_bias_on, pfd_lock_gate_run, pump_output_on, modulator_run;
  wire lock_detect_run, slip_prevention_run, ref_divider_in_use, sine_ref_select, prescaler_long_low;
  wire [13:0] ref_div_ratio;
  wire [2:0] pfd_delay_setpoint;
  wire [4:0] pump_up_current_code, pump_down_current_code;
  reg [15:0] en_m;
  reg [16:0] rp_m;
  reg [9:0] cp_m;
  reg [2:0] pfd_m, dly_m;
  reg [1:0] frc_m;
  reg pr_m, u, dv;
  reg [23:0] q, d;
  reg [5:0] a;
  integer failures = 0, compares = 0, n_dig = 0, n_temp = 0, nd, nt, k;
  scr_core_regs #(.ID_WORD(ID)) scr_core_regs_inst (.clk_sys(clk_sys), .rst(rst), .spi_sck(spi_sck),
    .spi_sen(spi_sen), .spi_sdi(spi_sdi), .lock_or_serial_out_pin(lock_or_serial_out_pin),
    .lock_or_serial_out_pin_oe(lock_or_serial_out_pin_oe), .lock_detect(lock_detect), .pfd_up_raw(pfd_up_raw),
    .pfd_dn_raw(pfd_dn_raw), .pump_up_cmd(pump_up_cmd), .pump_dn_cmd(pump_dn_cmd), .pump_output_oe(pump_output_oe),
    .digital_soft_reset(digital_soft_reset), .temp_sample_strobe(temp_sample_strobe), .vco_buffer_on(vco_buffer_on),
    .bias_on(bias_on), .ref_divider_run(ref_divider_run), .xmux_clk_to_dig_on(xmux_clk_to_dig_on),
    .rdiv_clk_to_dig_on(rdiv_clk_to_dig_on), .sqr_clk_to_dig_on(sqr_clk_to_dig_on),
    .sin_clk_to_dig_on(sin_clk_to_dig_on), .square_ref_buffer_on(square_ref_buffer_on),
    .sine_ref_buffer_on(sine_ref_buffer_on), .mod_clk_from_vco(mod_clk_from_vco),
    .prescaler_bias_on(prescaler_bias_on), .pfd_lock_gate_run(pfd_lock_gate_run), .pump_output_on(pump_output_on),
    .modulator_run(modulator_run), .lock_detect_run(lock_detect_run), .slip_prevention_run(slip_prevention_run),
    .ref_div_ratio(ref_div_ratio), .ref_divider_in_use(ref_divider_in_use), .sine_ref_select(sine_ref_select),
    .prescaler_long_low(prescaler_long_low), .pfd_delay_setpoint(pfd_delay_setpoint),
    .pump_up_current_code(pump_up_current_code), .pump_down_current_code(pump_down_current_code));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (digital_soft_reset === 1'b1) n_dig <= n_dig + 1;
    if (temp_sample_strobe === 1'b1) n_temp <= n_temp + 1;
  end
  task chk(input [31:0] got, input [31:0] exp, input string msg);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED at %0t: %0s got %h expected %h", $time, msg, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("Counts: %0d failures, %0d compares", failures, compares);
      if (failures == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task defaults;
    begin
      en_m = `SCR_RST_ENABLE; frc_m = `SCR_RST_SDO_FORCE; rp_m = `SCR_RST_REFPATH; pr_m = `SCR_RST_PRESC;
      pfd_m = `SCR_RST_PFD; dly_m = `SCR_RST_PFD_DELAY; cp_m = `SCR_RST_PUMP;
    end
  endtask
  function exp_use(input dummy);
    exp_use = !en_m[2] ? 1'b0 : rp_m[15] ? (rp_m[13:0] != 14'h0001) : rp_m[14];
  endfunction
  function [23:0] exp_rd(input [5:0] ad);
    if (frc_m[1]) exp_rd = {24{frc_m[0]}};
    else case (ad)
      6'h00: exp_rd = ID;
      6'h01: exp_rd = en_m;
      6'h02: exp_rd = frc_m;
      6'h03: exp_rd = rp_m;
      6'h04: exp_rd = pr_m;
      6'h05: exp_rd = pfd_m;
      6'h06: exp_rd = dly_m;
      6'h07: exp_rd = cp_m;
      default: exp_rd = 24'h000000;
    endcase
  endfunction
  // Frame: read flag, spare bit, address, data; pin sampled before each SCK fall of the 24 data bits
  task xfer(input rd, input [5:0] ad, input [23:0] dat, output [23:0] rq);
    reg [31:0] f;
    integer b;
    begin
      f = {rd, 1'b0, ad, dat};
      @(negedge clk_sys) spi_sen = 1'b1;
      for (b = 31; b >= 0; b = b - 1) begin
        repeat (6) @(negedge clk_sys);
        spi_sdi = f[b];
        spi_sck = 1'b0;
        repeat (6) @(negedge clk_sys);
        spi_sck = 1'b1;
        repeat (6) @(negedge clk_sys);
        if (b < 24) rq[b] = lock_or_serial_out_pin;
        spi_sck = 1'b0;
      end
      repeat (10) @(negedge clk_sys);
      spi_sen = 1'b0;
      repeat (10) @(negedge clk_sys);
    end
  endtask
  task wr(input [5:0] ad, input [23:0] dat);
    begin
      xfer(1'b0, ad, dat, q);
      case (ad)
        6'h00: if (dat[0]) defaults;
        6'h01: en_m = dat[15:0];
        6'h02: frc_m = dat[1:0];
        6'h03: rp_m = dat[16:0];
        6'h04: pr_m = dat[0];
        6'h05: pfd_m = dat[2:0];
        6'h06: dly_m = dat[2:0];
        6'h07: cp_m = dat[9:0];
        default: ;
      endcase
    end
  endtask
  task rd_chk(input [5:0] ad);
    begin
      xfer(1'b1, ad, 24'h000000, q);
      chk(q, exp_rd(ad), "read data");
    end
  endtask
  task chk_outs;
    begin
      chk({slip_prevention_run, lock_detect_run, modulator_run, pump_output_on, pfd_lock_gate_run, prescaler_bias_on,
        mod_clk_from_vco, sine_ref_buffer_on, square_ref_buffer_on, sin_clk_to_dig_on, sqr_clk_to_dig_on,
        rdiv_clk_to_dig_on, xmux_clk_to_dig_on, ref_divider_run, bias_on, vco_buffer_on}, en_m, "enables");
      chk({sine_ref_select, ref_divider_in_use, ref_div_ratio}, {rp_m[16], exp_use(0), rp_m[13:0]}, "ref");
      chk({prescaler_long_low, pfd_delay_setpoint, pump_down_current_code, pump_up_current_code},
        {pr_m, dly_m, cp_m}, "codes");
      @(negedge clk_sys);
      {pfd_up_raw, pfd_dn_raw} = $urandom;
      #5;
      u = pfd_m[0] ? pfd_dn_raw : pfd_up_raw;
      dv = pfd_m[0] ? pfd_up_raw : pfd_dn_raw;
      chk({pump_up_cmd, pump_dn_cmd, pump_output_oe},
        {u & pfd_m[1] & en_m[12], dv & pfd_m[2] & en_m[12], en_m[12]}, "pump");
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures = failures + 1;
    end_sim;
  end
  initial begin
    k = $urandom(41024);
    defaults;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk_outs;
    rd_chk(6'h00);
    wr(6'h02, 24'h000002);
    chk(lock_or_serial_out_pin, 1'b0, "forced pin");
    wr(6'h02, 24'h000000);
    for (k = 0; k < 2; k = k + 1) begin
      lock_detect = k;
      repeat (6) @(negedge clk_sys);
      chk(lock_or_serial_out_pin, k, "idle pin");
    end
    for (k = 0; k < 4; k = k + 1) begin
      nd = n_dig;
      nt = n_temp;
      wr(6'h00, {$urandom, STB_TBL[k*4 +: 4]} & 24'hfffffe);
      chk(n_dig - nd, STB_TBL[k*4+1], "digital reset strobes");
      chk(n_temp - nt, STB_TBL[k*4+3], "temperature strobes");
      rd_chk(6'h00);
    end
    for (k = 0; k < 12; k = k + 1) begin
      a = $urandom_range(7, 1);
      d = $urandom;
      if (a == 6'h03 && d[13:0] == 14'h0000) d[0] = 1'b1;
      wr(a, d);
      chk_outs;
      rd_chk(a);
    end
    wr(6'h02, 24'h000000);
    wr(6'h01, en_m | 16'h0004);
    for (k = 0; k < 5; k = k + 1) begin
      wr(6'h03, RP_TBL[k*17 +: 17]);
      chk_outs;
    end
    wr(6'h01, en_m & 16'hfffb);
    chk_outs;
    wr(6'h3f, 24'hffffff);
    chk_outs;
    rd_chk(6'h3f);
    wr(6'h00, 24'h000001);
    chk_outs;
    rd_chk(6'h01);
    end_sim;
  end
endmodule // scr_core_regs_test

/* File: scr_defines.vh */
// Register map, field positions and reset values of the synthesizer control bank
`ifndef SCR_DEFINES_VH
`define SCR_DEFINES_VH
`define SCR_ADDR_W 6
`define SCR_DATA_W 24
`define SCR_FRAME_W 32
`define SCR_ADDR_ID_STROBE 6'h00
`define SCR_ADDR_ENABLE 6'h01
`define SCR_ADDR_SDO_FORCE 6'h02
`define SCR_ADDR_REFPATH 6'h03
`define SCR_ADDR_PRESC 6'h04
`define SCR_ADDR_PFD 6'h05
`define SCR_ADDR_PFD_DELAY 6'h06
`define SCR_ADDR_PUMP 6'h07
`define SCR_CNT_ADDR_DONE 6'h07
`define SCR_CNT_LAST 6'h1f
`define SCR_READ_FLAG_BIT 7
`define SCR_STB_REGS 0
`define SCR_STB_DIG 1
`define SCR_STB_TEMP 3
`define SCR_EN_VCOBUF 0
`define SCR_EN_BIAS 1
`define SCR_EN_REFDIV 2
`define SCR_EN_XMUX_DIG 3
`define SCR_EN_RDIV_DIG 4
`define SCR_EN_SQR_DIG 5
`define SCR_EN_SIN_DIG 6
`define SCR_EN_SQ_BUF 7
`define SCR_EN_SIN_BUF 8
`define SCR_EN_MODCLK_VCO 9
`define SCR_EN_PRESC 10
`define SCR_EN_PFD_LKD 11
`define SCR_EN_PUMP 12
`define SCR_EN_DSM_RSTB 13
`define SCR_EN_LKD_RSTB 14
`define SCR_EN_SLIP_RSTB 15
`define SCR_FRC_VAL 0
`define SCR_FRC_EN 1
`define SCR_RP_RATIO_MSB 13
`define SCR_RP_SELECT 14
`define SCR_RP_AUTO 15
`define SCR_RP_SIN_SEL 16
`define SCR_RP_RATIO_ONE 14'h0001
`define SCR_PFD_INVERT 0
`define SCR_PFD_UP_EN 1
`define SCR_PFD_DN_EN 2
`define SCR_PUMP_UP_MSB 4
`define SCR_PUMP_DN_LSB 5
`define SCR_PUMP_DN_MSB 9
`define SCR_RST_ENABLE 16'h948b
`define SCR_RST_SDO_FORCE 2'h3
`define SCR_RST_REFPATH 17'h00000
`define SCR_RST_PRESC 1'h0
`define SCR_RST_PFD 3'h6
`define SCR_RST_PFD_DELAY 3'h2
`define SCR_RST_PUMP 10'h210
`define SCR_RST_PUMP_UP 5'h10
`define SCR_RST_PUMP_DN 5'h10
`define SCR_RST_RATIO 14'h0000
`endif
